// *** common/bpst_pkg.sv ***
// Package for the bridge port spanning tree state block
package bpst_pkg;
	// Widths
	localparam int PORTS = 2;
	localparam int CNT_W = 8;
	localparam int EXC_W = 16;
	localparam int ADDR_W = 48;
	localparam int ID_W = 56;
	localparam int COST_W = 16;
	localparam int AGE_W = 8;
	localparam int FD_W = 8;
	localparam int PNUM_W = 8;
	// Identifier layout: priority in the top byte
	localparam int ID_PRIO_LSB = 48;
	// Reset values
	localparam logic [CNT_W-1:0] CNT_RST = 8'h00;
	localparam logic [EXC_W-1:0] EXC_RST = 16'h0000;
	localparam logic [COST_W-1:0] LINE_COST_RST = 16'h000a;
	localparam logic [ID_W-1:0] ID_RST = 56'hff_ffff_ffff_ffff;
	localparam logic [COST_W-1:0] COST_RST = 16'hffff;
	localparam logic [AGE_W-1:0] AGE_RST = 8'h00;
	localparam logic [FD_W-1:0] FD_RST = 8'h0f;
	// Timing: one second at 100 MHz
	localparam int CLK_MHZ = 100;
	localparam int SEC_NS = 1000000000;
	localparam int SEC_CYC = SEC_NS / 1000 * CLK_MHZ;
	localparam int SEC_W = 27;

	// Spanning tree modes
	typedef enum logic {BPST_MODE_STD, BPST_MODE_LEGACY} bpst_mode_t;

	// Received Hello summary for one port
	typedef struct packed {
		logic valid;
		logic mode_legacy;
		logic [ID_W-1:0] root_id;
		logic [COST_W-1:0] cost;
		logic [ID_W-1:0] br_id;
		logic [PNUM_W-1:0] br_port;
		logic [AGE_W-1:0] age;
		logic tcn;
	} bpst_hello_t;

	// Per-port readable state
	typedef struct packed {
		logic [CNT_W-1:0] bad_cnt;
		logic [CNT_W-1:0] clear_cnt;
		logic ack;
		logic loop;
		logic [ID_W-1:0] desg_br;
		logic [PNUM_W-1:0] desg_port;
		logic [COST_W-1:0] desg_cost;
		logic [ID_W-1:0] desg_root;
		logic [AGE_W-1:0] root_age;
		logic [FD_W-1:0] fwd_delay;
		logic fwd;
		logic [COST_W-1:0] line_cost;
	} bpst_port_t;
endpackage : bpst_pkg

// *** verilog/bpst_core.sv ***
// Per-port spanning tree state and Hello health for a two-port bridge
// Summary of operation
// - Count intervals having bad Hellos, consecutive or not
// - At limit clear, bump exceeded, link test
// - Reset interval first clears bad count
// - Count clean intervals; at interval clear both
// - Keep limit-exceeded count since initialization; both ports at limit in one tick add one
// - Set ack flag on TCN from below
// - Hold designated bridge, port, cost, root
// - Age designated root Hello in seconds
// - Count down forward delay to forwarding
// - Only line cost is management-writable
// - Each port holds its own address
// - Loop seen with bad count sets flag
// - Root is the lowest bridge identifier
// - Priority is top byte, compared first
// - Root path cost sums inlink line costs
// - Designated: lowest root identifier, then lowest cost
// - Only root originates Hello messages
// - Ignore Hellos of the other mode
// - Auto-select switch or fixed standard mode
// - Bad Hello restarts the clear count
module bpst_core #(
	parameter int PORTS = bpst_pkg::PORTS,
	parameter int SEC_CYC = bpst_pkg::SEC_CYC
) (
	// Clock and reset
	input wire logic clock_i,
	input wire logic rst_b_i,
	// Timing and Hello traffic
	input wire logic hello_tick_i,
	input wire logic [PORTS-1:0] bad_hello_i,
	input wire bpst_pkg::bpst_hello_t [PORTS-1:0] hello_i,
	input wire logic [PORTS-1:0] loop_detect_i,
	input wire logic [PORTS-1:0] ack_sent_i,
	// Configuration from management
	input wire logic [bpst_pkg::CNT_W-1:0] bad_limit_i,
	input wire logic [bpst_pkg::CNT_W-1:0] reset_interval_i,
	input wire logic [bpst_pkg::FD_W-1:0] fwd_delay_cfg_i,
	input wire logic [7:0] root_prio_i,
	input wire logic [bpst_pkg::ADDR_W-1:0] bridge_addr_i,
	input wire logic [PORTS*bpst_pkg::ADDR_W-1:0] port_addr_i,
	input wire logic auto_select_i,
	input wire logic [PORTS-1:0] line_cost_we_i,
	input wire logic [bpst_pkg::COST_W-1:0] line_cost_wdata_i,
	// Status outputs
	output bpst_pkg::bpst_port_t [PORTS-1:0] port_o,
	output logic [PORTS*bpst_pkg::ADDR_W-1:0] port_addr_o,
	output logic [bpst_pkg::EXC_W-1:0] exceeded_o,
	output logic [PORTS-1:0] link_test_o,
	output logic [bpst_pkg::ID_W-1:0] root_id_o,
	output logic [bpst_pkg::COST_W-1:0] my_cost_o,
	output logic is_root_o,
	output logic hello_send_o,
	output logic mode_legacy_o
);
	// All state of the block except the input synchronisers
	typedef struct packed {
		bpst_pkg::bpst_port_t [PORTS-1:0] port;
		logic [PORTS*bpst_pkg::ADDR_W-1:0] paddr;
		logic [bpst_pkg::EXC_W-1:0] exc;
		logic [PORTS-1:0] ltest;
		logic [PORTS-1:0] bad_seen;
		logic [bpst_pkg::SEC_W-1:0] sec_cnt;
		logic [bpst_pkg::ID_W-1:0] root_id;
		logic [bpst_pkg::COST_W-1:0] my_cost;
		logic is_root;
		logic hsend;
		bpst_pkg::bpst_mode_t mode;
		logic strap_done;
	} bpst_state_t;

	bpst_state_t st;
	bpst_state_t next_st;

	// Synchronised pin-level status inputs
	logic [PORTS-1:0] loop_s1;
	logic [PORTS-1:0] loop_s2;
	logic auto_s1;
	logic auto_s2;

	// Own identifier: priority byte over hardware address
	logic [bpst_pkg::ID_W-1:0] own_id;
	assign own_id = {root_prio_i, bridge_addr_i};

	// Loop detect and auto-select come from outside the domain
	always_ff @(posedge clock_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			loop_s1 <= '0;
			loop_s2 <= '0;
			auto_s1 <= 1'b0;
			auto_s2 <= 1'b0;
		end else begin
			loop_s1 <= loop_detect_i;
			loop_s2 <= loop_s1;
			auto_s1 <= auto_select_i;
			auto_s2 <= auto_s1;
		end
	end

	// Next-state logic
	always_comb begin
		logic sec_pulse;
		logic hit;
		logic [bpst_pkg::ID_W-1:0] best_root;
		logic [bpst_pkg::COST_W-1:0] best_cost;
		logic found;
		logic [bpst_pkg::COST_W-1:0] cand;
		logic [bpst_pkg::CNT_W-1:0] bad_nxt;
		sec_pulse = 1'b0;
		hit = 1'b0;
		best_root = own_id;
		best_cost = '0;
		found = 1'b0;
		cand = '0;
		bad_nxt = '0;
		next_st = st;
		next_st.ltest = '0;
		next_st.hsend = 1'b0;

		// Port addresses caught once after reset release
		if (!st.strap_done) begin
			next_st.paddr = port_addr_i;
			next_st.strap_done = 1'b1;
		end

		// One-second enable for age counting
		if (st.sec_cnt == bpst_pkg::SEC_W'(SEC_CYC - 1)) begin
			next_st.sec_cnt = '0;
			sec_pulse = 1'b1;
		end else begin
			next_st.sec_cnt = st.sec_cnt + 1'b1;
		end

		// Mode: auto-select follows the network, otherwise standard
		if (!auto_s2) begin
			next_st.mode = bpst_pkg::BPST_MODE_STD;
		end else begin
			for (int p = 0; p < PORTS; p++) begin
				if (hello_i[p].valid && hello_i[p].mode_legacy) begin
					next_st.mode = bpst_pkg::BPST_MODE_LEGACY;
				end
			end
		end

		for (int p = 0; p < PORTS; p++) begin
			// Management writes only the line cost
			if (line_cost_we_i[p]) begin
				next_st.port[p].line_cost = line_cost_wdata_i;
			end

			// Bad Hello seen within the current interval
			if (bad_hello_i[p]) begin
				next_st.bad_seen[p] = 1'b1;
			end

			// Interval bookkeeping on the Hello tick
			if (hello_tick_i) begin
				// A bad Hello in the tick cycle belongs to the ended interval
				next_st.bad_seen[p] = 1'b0;
				if (st.bad_seen[p] || bad_hello_i[p]) begin
					next_st.port[p].clear_cnt = '0;
					bad_nxt = st.port[p].bad_cnt + 1'b1;
					if (bad_nxt >= bad_limit_i) begin
						next_st.port[p].bad_cnt = '0;
						next_st.exc = st.exc + 1'b1;
						next_st.ltest[p] = 1'b1;
					end else begin
						next_st.port[p].bad_cnt = bad_nxt;
					end
				end else if (st.port[p].clear_cnt + 1'b1 >= reset_interval_i)
				begin
					next_st.port[p].clear_cnt = '0;
					next_st.port[p].bad_cnt = '0;
				end else begin
					next_st.port[p].clear_cnt = st.port[p].clear_cnt + 1'b1;
				end
			end

			// Possible loop while bad count is nonzero
			if (loop_s2[p] && st.port[p].bad_cnt != '0) begin
				next_st.port[p].loop = 1'b1;
			end

			// Hello of our mode only updates stored values
			hit = hello_i[p].valid &&
				(hello_i[p].mode_legacy == (st.mode ==
				bpst_pkg::BPST_MODE_LEGACY));
			if (hit) begin
				next_st.port[p].desg_br = hello_i[p].br_id;
				next_st.port[p].desg_port = hello_i[p].br_port;
				next_st.port[p].desg_cost = hello_i[p].cost;
				next_st.port[p].desg_root = hello_i[p].root_id;
				next_st.port[p].root_age = hello_i[p].age;
			end else if (sec_pulse && st.port[p].root_age != '1) begin
				next_st.port[p].root_age = st.port[p].root_age + 1'b1;
			end

			// Acknowledge flag set, then cleared when the Hello carries it
			if (hit && hello_i[p].tcn) begin
				next_st.port[p].ack = 1'b1;
			end else if (ack_sent_i[p]) begin
				next_st.port[p].ack = 1'b0;
			end

			// Forward delay countdown, restarted on root change
			if (st.port[p].fwd) begin
				next_st.port[p].fwd_delay = '0;
			end else if (sec_pulse) begin
				if (st.port[p].fwd_delay <= bpst_pkg::FD_W'(1)) begin
					next_st.port[p].fwd_delay = '0;
					next_st.port[p].fwd = 1'b1;
				end else begin
					next_st.port[p].fwd_delay = st.port[p].fwd_delay - 1'b1;
				end
			end
		end

		// Root election over stored Hellos: lowest id then lowest cost
		for (int p = 0; p < PORTS; p++) begin
			cand = st.port[p].desg_cost + st.port[p].line_cost;
			if (st.port[p].desg_root < best_root ||
				(found && st.port[p].desg_root == best_root &&
				cand < best_cost)) begin
				best_root = st.port[p].desg_root;
				best_cost = cand;
				found = 1'b1;
			end
		end
		next_st.root_id = best_root;
		next_st.my_cost = found ? best_cost : '0;
		next_st.is_root = !found;
		if (next_st.root_id != st.root_id) begin
			for (int p = 0; p < PORTS; p++) begin
				next_st.port[p].fwd = 1'b0;
				next_st.port[p].fwd_delay = fwd_delay_cfg_i;
			end
		end

		// Only the root originates Hellos, once per interval
		next_st.hsend = hello_tick_i && st.is_root;
	end

	// State register
	always_ff @(posedge clock_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			for (int p = 0; p < PORTS; p++) begin
				st.port[p].bad_cnt <= bpst_pkg::CNT_RST;
				st.port[p].clear_cnt <= bpst_pkg::CNT_RST;
				st.port[p].ack <= 1'b0;
				st.port[p].loop <= 1'b0;
				st.port[p].desg_br <= bpst_pkg::ID_RST;
				st.port[p].desg_port <= '0;
				st.port[p].desg_cost <= bpst_pkg::COST_RST;
				st.port[p].desg_root <= bpst_pkg::ID_RST;
				st.port[p].root_age <= bpst_pkg::AGE_RST;
				st.port[p].fwd_delay <= bpst_pkg::FD_RST;
				st.port[p].fwd <= 1'b0;
				st.port[p].line_cost <= bpst_pkg::LINE_COST_RST;
			end
			st.paddr <= '0;
			st.exc <= bpst_pkg::EXC_RST;
			st.ltest <= '0;
			st.bad_seen <= '0;
			st.sec_cnt <= '0;
			st.root_id <= bpst_pkg::ID_RST;
			st.my_cost <= '0;
			st.is_root <= 1'b1;
			st.hsend <= 1'b0;
			st.mode <= bpst_pkg::BPST_MODE_STD;
			st.strap_done <= 1'b0;
		end else begin
			st <= next_st;
		end
	end

	// Outputs straight from state
	assign port_o = st.port;
	assign port_addr_o = st.paddr;
	assign exceeded_o = st.exc;
	assign link_test_o = st.ltest;
	assign root_id_o = st.root_id;
	assign my_cost_o = st.my_cost;
	assign is_root_o = st.is_root;
	assign hello_send_o = st.hsend;
	assign mode_legacy_o = (st.mode == bpst_pkg::BPST_MODE_LEGACY);
endmodule : bpst_core

// *** dv/bpst_peer.sv ***
// Neighbour bridge model that sends root Hello summaries
module bpst_peer #(
	parameter logic [7:0] PRIO = 8'h10,
	parameter logic [47:0] ADDR = 48'h02_0000_0000_11
) (
	// Clock
	input wire logic clock_i,
	// Requests from the bench
	input wire logic send_i,
	input wire logic legacy_i,
	// Hello summary towards the port
	output bpst_pkg::bpst_hello_t hello_o
);
	timeunit 1ns;
	timeprecision 1ps;
	initial hello_o = '0;
	// Root Hello: id is priority over address, own cost zero
	always @(posedge clock_i) begin
		if (send_i) begin
			hello_o.valid <= 1'b1;
			hello_o.mode_legacy <= legacy_i;
			hello_o.root_id <= {PRIO, ADDR};
			hello_o.cost <= 16'h0000;
			hello_o.br_id <= {PRIO, ADDR};
			hello_o.br_port <= 8'h01;
			hello_o.age <= 8'h00;
			hello_o.tcn <= 1'b0;
		end else begin
			// Idle summary scrambles every cycle
			hello_o <= {1'b0, ~hello_o[$bits(hello_o)-2:0]};
		end
	end
endmodule : bpst_peer

// *** dv/bpst_core_sva.sv ***
// Port assertions for the spanning tree state block
module bpst_core_sva #(
	parameter int PORTS = bpst_pkg::PORTS,
	parameter int SEC_CYC = bpst_pkg::SEC_CYC
) (
	// Clock, reset and inputs
	input wire logic clock_i,
	input wire logic rst_b_i,
	input wire logic hello_tick_i,
	input wire logic [PORTS-1:0] bad_hello_i,
	input wire bpst_pkg::bpst_hello_t [PORTS-1:0] hello_i,
	input wire logic auto_select_i,
	input wire logic [PORTS-1:0] line_cost_we_i,
	input wire logic [bpst_pkg::COST_W-1:0] line_cost_wdata_i,
	// Outputs
	input wire bpst_pkg::bpst_port_t [PORTS-1:0] port_o,
	input wire logic [bpst_pkg::EXC_W-1:0] exceeded_o,
	input wire logic [PORTS-1:0] link_test_o,
	input wire logic hello_send_o,
	input wire logic mode_legacy_o
);
	default clocking cb @(posedge clock_i);
	endclocking
	default disable iff (!rst_b_i);
	// Port 0 Hello health
	a_link_pulse: assert property (link_test_o[0] |=> !link_test_o[0])
		else $error("link test pulse too long");
	a_link_clear: assert property (link_test_o[0] |-> port_o[0].bad_cnt == 8'h00)
		else $error("bad count kept at link test");
	a_exc_step: assert property (link_test_o[0] && !link_test_o[1] |->
		exceeded_o == $past(exceeded_o) + 16'h0001) else $error("exceeded step");
	a_bad_count: assert property ($past(hello_tick_i && bad_hello_i[0]) &&
		!link_test_o[0] |-> port_o[0].bad_cnt == $past(port_o[0].bad_cnt) + 8'h01)
		else $error("bad count step");
	a_bad_restart: assert property ($past(hello_tick_i && bad_hello_i[0]) |->
		port_o[0].clear_cnt == 8'h00) else $error("clear count not restarted");
	// Line cost access
	a_cost_write: assert property (line_cost_we_i[0] |=>
		port_o[0].line_cost == $past(line_cost_wdata_i)) else $error("cost write");
	a_cost_hold: assert property (!line_cost_we_i[0] |=>
		$stable(port_o[0].line_cost)) else $error("cost changed");
	// Hello output and modes
	a_hello_pulse: assert property (hello_send_o |=> !hello_send_o)
		else $error("hello pulse too long");
	a_other_mode: assert property (hello_i[0].valid && !auto_select_i &&
		hello_i[0].mode_legacy != mode_legacy_o |=> $stable(port_o[0].desg_root))
		else $error("foreign mode hello taken");
	c_link: cover property (link_test_o[0]);
	c_cost: cover property (line_cost_we_i[0]);
	c_root_lost: cover property ($fell(port_o[0].desg_root[55]));
endmodule : bpst_core_sva

bind bpst_core bpst_core_sva #(.PORTS(PORTS), .SEC_CYC(SEC_CYC)) bpst_core_sva_inst (
	.clock_i(clock_i), .rst_b_i(rst_b_i), .hello_tick_i(hello_tick_i),
	.bad_hello_i(bad_hello_i), .hello_i(hello_i), .auto_select_i(auto_select_i),
	.line_cost_we_i(line_cost_we_i), .line_cost_wdata_i(line_cost_wdata_i),
	.port_o(port_o), .exceeded_o(exceeded_o), .link_test_o(link_test_o),
	.hello_send_o(hello_send_o), .mode_legacy_o(mode_legacy_o));

// *** dv/tb_bpst_core.sv ***
// Self-checking bench for the spanning tree state block
module tb_bpst_core;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [47:0] PEER = 48'h02_0000_0000_11;
	logic clk = 1'b0;
	logic rst_b = 1'b0;
	logic tick = 1'b0;
	logic send = 1'b0;
	logic legacy = 1'b0;
	logic auto_sel = 1'b0;
	logic [1:0] bad = '0;
	logic [1:0] loop = '0;
	logic [1:0] cost_we = '0;
	logic [15:0] cost_wd = '0;
	logic [7:0] limit = 8'h02;
	logic [7:0] clr_int = 8'h03;
	logic [7:0] own_prio = 8'h80;
	logic [47:0] own_addr = 48'h02_0000_0000_80;
	logic [95:0] paddr = 96'h02_0000_0000_81_02_0000_0000_82;
	bpst_pkg::bpst_hello_t peer_hello;
	bpst_pkg::bpst_port_t [1:0] port;
	logic [95:0] paddr_q;
	logic [15:0] exceeded;
	logic [1:0] link_test;
	logic [55:0] root_id;
	logic [15:0] my_cost;
	logic is_root;
	logic hello_send;
	logic mode_legacy;
	int failures = 0;
	int check_count = 0;
	always #5 clk = ~clk;
	bpst_peer bpst_peer_inst (.clock_i(clk), .send_i(send), .legacy_i(legacy),
		.hello_o(peer_hello));
	bpst_core #(.SEC_CYC(10)) bpst_core_inst (.clock_i(clk), .rst_b_i(rst_b),
		.hello_tick_i(tick), .bad_hello_i(bad),
		.hello_i({bpst_pkg::bpst_hello_t'('0), peer_hello}),
		.loop_detect_i(loop), .ack_sent_i(2'b00), .bad_limit_i(limit),
		.reset_interval_i(clr_int), .fwd_delay_cfg_i(8'h0f),
		.root_prio_i(own_prio), .bridge_addr_i(own_addr), .port_addr_i(paddr),
		.auto_select_i(auto_sel), .line_cost_we_i(cost_we),
		.line_cost_wdata_i(cost_wd), .port_o(port), .port_addr_o(paddr_q),
		.exceeded_o(exceeded), .link_test_o(link_test), .root_id_o(root_id),
		.my_cost_o(my_cost), .is_root_o(is_root), .hello_send_o(hello_send),
		.mode_legacy_o(mode_legacy));
	// Compare and count
	task automatic check(input string what, input logic [95:0] exp, got);
		check_count++;
		if (exp !== got) begin
			failures++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask : check
	// Verdict and end of run
	task automatic final_report;
		if (failures == 0 && check_count > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask : final_report
	// One Hello interval, bad Hello or not
	task automatic interval(input logic b);
		@(negedge clk);
		tick = 1'b1;
		bad[0] = b;
		@(negedge clk);
		tick = 1'b0;
		bad[0] = 1'b0;
	endtask : interval
	// Values after reset
	task automatic t_reset;
		check("line_cost", 16'h000a, port[0].line_cost);
		check("desg_cost", 16'hffff, port[0].desg_cost);
		check("exceeded", 16'h0000, exceeded);
		check("port_addr", paddr, paddr_q);
		check("is_root", 1'b1, is_root);
	endtask : t_reset
	// Two bad intervals reach a limit of two
	task automatic t_limit;
		interval(1'b1);
		check("hello_send", 1'b1, hello_send);
		check("bad_cnt", 8'h01, port[0].bad_cnt);
		interval(1'b1);
		check("link_test", 2'b01, link_test);
		check("bad_cnt", 8'h00, port[0].bad_cnt);
		check("exceeded", 16'h0001, exceeded);
		@(negedge clk);
		check("link_test", 2'b00, link_test);
	endtask : t_limit
	// Loop flag, then three clean intervals clear the count
	task automatic t_clear;
		interval(1'b1);
		loop[0] = 1'b1;
		repeat (4) @(negedge clk);
		check("loop", 1'b1, port[0].loop);
		loop[0] = 1'b0;
		interval(1'b0);
		interval(1'b0);
		check("clear_cnt", 8'h02, port[0].clear_cnt);
		check("bad_cnt", 8'h01, port[0].bad_cnt);
		interval(1'b0);
		check("clear_cnt", 8'h00, port[0].clear_cnt);
		check("bad_cnt", 8'h00, port[0].bad_cnt);
		check("exceeded", 16'h0001, exceeded);
	endtask : t_clear
	// Line cost write on port 0 only
	task automatic t_cost;
		@(negedge clk);
		cost_we = 2'b01;
		cost_wd = 16'h0005;
		@(negedge clk);
		cost_we = 2'b00;
		check("line_cost0", 16'h0005, port[0].line_cost);
		check("line_cost1", 16'h000a, port[1].line_cost);
	endtask : t_cost
	// Send one Hello from the peer, settle two cycles
	task automatic hello(input logic lg);
		@(negedge clk);
		send = 1'b1;
		legacy = lg;
		@(negedge clk);
		send = 1'b0;
		repeat (2) @(negedge clk);
	endtask : hello
	// Foreign-mode Hello ignored, then a lower root is taken
	task automatic t_hello;
		hello(1'b1);
		check("desg_root", 56'hff_ffff_ffff_ffff, port[0].desg_root);
		hello(1'b0);
		check("desg_root", {8'h10, PEER}, port[0].desg_root);
		check("root_id", {8'h10, PEER}, root_id);
		check("desg_port", 8'h01, port[0].desg_port);
		check("is_root", 1'b0, is_root);
		check("my_cost", 16'h0005, my_cost);
		check("mode", 1'b0, mode_legacy);
		interval(1'b0);
		check("hello_send", 1'b0, hello_send);
	endtask : t_hello
	// Main sequence
	initial begin
		repeat (10) @(negedge clk);
		rst_b = 1'b1;
		repeat (2) @(negedge clk);
		t_reset();
		t_limit();
		t_clear();
		t_cost();
		t_hello();
		final_report();
	end
	// Watchdog well past the expected run of about 41 cycles
	initial begin
		#20us;
		failures++;
		final_report();
	end
endmodule : tb_bpst_core
